// ### hdl/rcc_bcd_step.sv
// One BCD counter step with wrap to a first value
`timescale 1ns/1ns
module rcc_bcd_step #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] cur,
    input  wire logic [W-1:0] first,
    input  wire logic [W-1:0] last,
    output logic      [W-1:0] nxt,
    output logic              wrap
);
    wire logic [W-5:0] tens_up;
    wire logic [W-1:0] unit_up;

    assign tens_up = cur[W-1:4] + {{(W-5){1'b0}}, 1'b1};
    assign unit_up = cur + {{(W-1){1'b0}}, 1'b1};
    // Out-of-range values written by the host also wrap
    assign wrap    = (cur >= last);
    assign nxt     = wrap ? first :
                     (cur[3:0] >= 4'h9) ? {tens_up, 4'h0} : unit_up;

endmodule : rcc_bcd_step

// ### hdl/rcc_pkg.sv
// Constants, types and register map of the calendar core
package rcc_pkg;

    // Bus address, write form shifted right by one
    localparam logic [6:0] DEV_ADDR   = 7'h51;
    localparam logic [3:0] BYTE_BITS  = 4'h8;

    // Register pointers
    localparam logic [3:0] A_CTRL1    = 4'h0;
    localparam logic [3:0] A_CTRL2    = 4'h1;
    localparam logic [3:0] A_SEC      = 4'h2;
    localparam logic [3:0] A_MIN      = 4'h3;
    localparam logic [3:0] A_HOUR     = 4'h4;
    localparam logic [3:0] A_DAY      = 4'h5;
    localparam logic [3:0] A_WDAY     = 4'h6;
    localparam logic [3:0] A_MON      = 4'h7;
    localparam logic [3:0] A_YEAR     = 4'h8;
    localparam logic [3:0] A_AMIN     = 4'h9;
    localparam logic [3:0] A_AHOUR    = 4'ha;
    localparam logic [3:0] A_ADAY     = 4'hb;
    localparam logic [3:0] A_AWDAY    = 4'hc;

    // Implemented bits of each register
    localparam logic [7:0] M_SEC      = 8'h7f;
    localparam logic [7:0] M_MIN      = 8'h7f;
    localparam logic [7:0] M_HOUR     = 8'h3f;
    localparam logic [7:0] M_DAY      = 8'h3f;
    localparam logic [7:0] M_WDAY     = 8'h07;
    localparam logic [7:0] M_MON      = 8'h1f;
    localparam logic [7:0] M_YEAR     = 8'hff;
    localparam logic [7:0] M_AMIN     = 8'hff;
    localparam logic [7:0] M_AHOUR    = 8'hbf;
    localparam logic [7:0] M_ADAY     = 8'hbf;
    localparam logic [7:0] M_AWDAY    = 8'h87;

    // Field positions
    localparam int         AF_BIT     = 3;
    localparam int         VL_BIT     = 7;
    localparam int         CEN_BIT    = 7;
    localparam int         AE_BIT     = 7;

    // Reset values
    localparam logic [7:0] RST_ALARM  = 8'h80;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_ONE    = 8'h01;

    // Counting limits in BCD
    localparam logic [7:0] SEC_LAST   = 8'h59;
    localparam logic [7:0] HOUR_LAST  = 8'h23;
    localparam logic [7:0] MON_LAST   = 8'h12;
    localparam logic [7:0] YEAR_LAST  = 8'h99;
    localparam logic [7:0] DAY_28     = 8'h28;
    localparam logic [7:0] DAY_29     = 8'h29;
    localparam logic [7:0] DAY_30     = 8'h30;
    localparam logic [7:0] DAY_31     = 8'h31;
    localparam logic [7:0] MON_FEB    = 8'h02;
    localparam logic [7:0] MON_APR    = 8'h04;
    localparam logic [7:0] MON_JUN    = 8'h06;
    localparam logic [7:0] MON_SEP    = 8'h09;
    localparam logic [7:0] MON_NOV    = 8'h11;
    localparam logic [7:0] WDAY_LAST  = 8'h06;

    typedef struct packed {
        logic scl;
        logic sda;
    } rcc_i2c_in_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } rcc_i2c_out_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] wday;
        logic [7:0] mon;
        logic [7:0] year;
    } rcc_time_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_WR   = 7'h08,
        ST_WACK = 7'h10,
        ST_RD   = 7'h20,
        ST_RACK = 7'h40
    } rcc_state_t;

endpackage : rcc_pkg

// ### hdl/rcc_rtc_core.sv
// Calendar core with alarm and two-wire register access
`timescale 1ns/1ns
module rcc_rtc_core (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic                  tick_1hz,
    input  wire logic                  supply_low,
    input  wire rcc_pkg::rcc_i2c_in_t  i2c_in,
    output rcc_pkg::rcc_i2c_out_t      i2c_out,
    output logic                       alarm_flag,
    output logic                       access_busy
);
    import rcc_pkg::*;

    // Bus state
    rcc_state_t   state_q, state_d;
    logic [3:0]   cnt_q, cnt_d;
    logic [7:0]   sh_q, sh_d;
    logic [3:0]   ptr_q, ptr_d;
    logic         rw_q, rw_d;
    logic         first_q, first_d;
    logic         nack_q, nack_d;
    logic         busy_q, busy_d;
    logic         oe_d;
    logic         wr_en;
    logic         scl_q, sda_q;
    rcc_i2c_out_t out_q;

    // Time and alarm state
    rcc_time_t    tm_q, tm_d;
    logic         cen_q, cen_d;
    logic         vl_q, vl_d;
    logic         pend_q, pend_d;
    logic [7:0]   amin_q, ahour_q, aday_q, awday_q;
    logic         af_q, af_d;
    logic         match_q;

    // Bus line events
    wire logic scl_rise = i2c_in.scl & ~scl_q;
    wire logic scl_fall = ~i2c_in.scl & scl_q;
    wire logic start    = i2c_in.scl & scl_q & sda_q & ~i2c_in.sda;
    wire logic stop     = i2c_in.scl & scl_q & ~sda_q & i2c_in.sda;
    wire logic got_byte = (cnt_q == BYTE_BITS);
    wire logic [7:0] wd = sh_q;

    // Register read selection
    wire logic [7:0] rd_byte =
        (ptr_q == A_CTRL2) ? {4'h0, af_q, 3'h0} :
        (ptr_q == A_SEC)   ? {vl_q, tm_q.sec[6:0]} :
        (ptr_q == A_MIN)   ? tm_q.min :
        (ptr_q == A_HOUR)  ? tm_q.hour :
        (ptr_q == A_DAY)   ? tm_q.day :
        (ptr_q == A_WDAY)  ? tm_q.wday :
        (ptr_q == A_MON)   ? {cen_q, tm_q.mon[6:0]} :
        (ptr_q == A_YEAR)  ? tm_q.year :
        (ptr_q == A_AMIN)  ? amin_q :
        (ptr_q == A_AHOUR) ? ahour_q :
        (ptr_q == A_ADAY)  ? aday_q :
        (ptr_q == A_AWDAY) ? awday_q : 8'h00;

    // Bus slave state machine
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        first_d = first_q;
        nack_d  = nack_q;
        busy_d  = busy_q;
        oe_d    = out_q.sda_oe;
        wr_en   = 1'b0;
        if (start) begin
            state_d = ST_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
            busy_d  = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], i2c_in.sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && got_byte) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            state_d = ST_AACK;
                            oe_d    = 1'b1;
                            rw_d    = sh_q[0];
                            busy_d  = 1'b1;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            state_d = ST_RD;
                            sh_d    = rd_byte;
                            oe_d    = ~rd_byte[7];
                        end else begin
                            state_d = ST_WR;
                            oe_d    = 1'b0;
                            first_d = 1'b1;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], i2c_in.sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && got_byte) begin
                        state_d = ST_WACK;
                        oe_d    = 1'b1;
                        cnt_d   = 4'h0;
                        first_d = 1'b0;
                        wr_en   = ~first_q;
                        ptr_d   = first_q ? sh_q[3:0] : ptr_q + 4'h1;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        state_d = ST_WR;
                        oe_d    = 1'b0;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && got_byte) begin
                        state_d = ST_RACK;
                        oe_d    = 1'b0;
                        ptr_d   = ptr_q + 4'h1;
                    end else if (scl_fall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_d = i2c_in.sda;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            state_d = ST_IDLE;
                        end else begin
                            state_d = ST_RD;
                            cnt_d   = 4'h0;
                            sh_d    = rd_byte;
                            oe_d    = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    // Counter steps
    logic [7:0] s_nxt, m_nxt, h_nxt, d_nxt, mo_nxt, y_nxt;
    logic       s_wrap, m_wrap, h_wrap, d_wrap, mo_wrap, y_wrap;

    wire logic leap = tm_q.year[4] ?
        (tm_q.year[3:0] == 4'h2 || tm_q.year[3:0] == 4'h6) :
        (tm_q.year[3:0] == 4'h0 || tm_q.year[3:0] == 4'h4 ||
         tm_q.year[3:0] == 4'h8);
    wire logic short_mon = (tm_q.mon == MON_APR) || (tm_q.mon == MON_JUN) ||
                           (tm_q.mon == MON_SEP) || (tm_q.mon == MON_NOV);
    wire logic [7:0] day_last =
        (tm_q.mon == MON_FEB) ? (leap ? DAY_29 : DAY_28) :
        short_mon ? DAY_30 : DAY_31;

    rcc_bcd_step u_sec (
        .cur (tm_q.sec), .first (RST_ZERO), .last (SEC_LAST),
        .nxt (s_nxt),    .wrap  (s_wrap));
    rcc_bcd_step u_min (
        .cur (tm_q.min), .first (RST_ZERO), .last (SEC_LAST),
        .nxt (m_nxt),    .wrap  (m_wrap));
    rcc_bcd_step u_hour (
        .cur (tm_q.hour), .first (RST_ZERO), .last (HOUR_LAST),
        .nxt (h_nxt),     .wrap  (h_wrap));
    rcc_bcd_step u_day (
        .cur (tm_q.day), .first (RST_ONE), .last (day_last),
        .nxt (d_nxt),    .wrap  (d_wrap));
    rcc_bcd_step u_mon (
        .cur (tm_q.mon), .first (RST_ONE), .last (MON_LAST),
        .nxt (mo_nxt),   .wrap  (mo_wrap));
    rcc_bcd_step u_year (
        .cur (tm_q.year), .first (RST_ZERO), .last (YEAR_LAST),
        .nxt (y_nxt),     .wrap  (y_wrap));

    // Carry chain, held off while the host owns the bus
    wire logic adv    = ~busy_q & (tick_1hz | pend_q);
    wire logic c_min  = adv & s_wrap;
    wire logic c_hour = c_min & m_wrap;
    wire logic c_day  = c_hour & h_wrap;
    wire logic c_mon  = c_day & d_wrap;
    wire logic c_year = c_mon & mo_wrap;
    wire logic c_cen  = c_year & y_wrap;
    wire logic [7:0] wday_nxt = (tm_q.wday >= WDAY_LAST) ? RST_ZERO :
                                tm_q.wday + 8'h01;

    always_comb begin
        tm_d = tm_q;
        cen_d = cen_q;
        vl_d  = vl_q | supply_low;
        if (wr_en) begin
            unique case (ptr_q)
                A_SEC: begin
                    tm_d.sec = wd & M_SEC;
                    vl_d     = wd[VL_BIT] | supply_low;
                end
                A_MIN:   tm_d.min  = wd & M_MIN;
                A_HOUR:  tm_d.hour = wd & M_HOUR;
                A_DAY:   tm_d.day  = wd & M_DAY;
                A_WDAY:  tm_d.wday = wd & M_WDAY;
                A_MON: begin
                    tm_d.mon = wd & M_MON;
                    cen_d    = wd[CEN_BIT];
                end
                A_YEAR:  tm_d.year = wd & M_YEAR;
                default: begin
                end
            endcase
        end else if (adv) begin
            tm_d.sec = s_nxt;
            if (c_min) begin
                tm_d.min = m_nxt;
            end
            if (c_hour) begin
                tm_d.hour = h_nxt;
            end
            if (c_day) begin
                tm_d.day  = d_nxt;
                tm_d.wday = wday_nxt;
            end
            if (c_mon) begin
                tm_d.mon = mo_nxt;
            end
            if (c_year) begin
                tm_d.year = y_nxt;
            end
            if (c_cen) begin
                cen_d = ~cen_q;
            end
        end
    end

    // One deferred tick at most
    assign pend_d = busy_q ? (pend_q | tick_1hz) : (pend_q & tick_1hz);

    // Alarm comparison
    wire logic en_m = ~amin_q[AE_BIT];
    wire logic en_h = ~ahour_q[AE_BIT];
    wire logic en_d = ~aday_q[AE_BIT];
    wire logic en_w = ~awday_q[AE_BIT];
    wire logic eq_m = (amin_q & M_MIN) == tm_q.min;
    wire logic eq_h = (ahour_q & M_HOUR) == tm_q.hour;
    wire logic eq_d = (aday_q & M_DAY) == tm_q.day;
    wire logic eq_w = (awday_q & M_WDAY) == tm_q.wday;
    wire logic match = (en_m | en_h | en_d | en_w) &
                       (~en_m | eq_m) & (~en_h | eq_h) &
                       (~en_d | eq_d) & (~en_w | eq_w);
    wire logic af_clr = wr_en & (ptr_q == A_CTRL2) & ~wd[AF_BIT];
    // New match sets, and a set beats a clear in the same cycle
    assign af_d = (match & ~match_q) | (af_q & ~af_clr);

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 4'h0;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
            nack_q  <= 1'b0;
            busy_q  <= 1'b0;
            out_q   <= '{sda_o: 1'b0, sda_oe: 1'b0};
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            first_q <= first_d;
            nack_q  <= nack_d;
            busy_q  <= busy_d;
            out_q   <= '{sda_o: 1'b0, sda_oe: oe_d};
            scl_q   <= i2c_in.scl;
            sda_q   <= i2c_in.sda;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tm_q    <= '{sec: RST_ZERO, min: RST_ZERO, hour: RST_ZERO,
                         day: RST_ONE, wday: RST_ZERO, mon: RST_ONE,
                         year: RST_ZERO};
            cen_q   <= 1'b0;
            vl_q    <= 1'b1;
            pend_q  <= 1'b0;
            af_q    <= 1'b0;
            match_q <= 1'b0;
        end else begin
            tm_q    <= tm_d;
            cen_q   <= cen_d;
            vl_q    <= vl_d;
            pend_q  <= pend_d;
            af_q    <= af_d;
            match_q <= match;
        end
    end

    // Alarm target registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            amin_q  <= RST_ALARM;
            ahour_q <= RST_ALARM;
            aday_q  <= RST_ALARM;
            awday_q <= RST_ALARM;
        end else if (wr_en) begin
            if (ptr_q == A_AMIN) amin_q <= wd & M_AMIN;
            if (ptr_q == A_AHOUR) ahour_q <= wd & M_AHOUR;
            if (ptr_q == A_ADAY) aday_q <= wd & M_ADAY;
            if (ptr_q == A_AWDAY) awday_q <= wd & M_AWDAY;
        end
    end

    assign i2c_out     = out_q;
    assign alarm_flag  = af_q;
    assign access_busy = busy_q;

endmodule : rcc_rtc_core

// ### testbench/rcc_host_model.sv
// Two-wire bus host model for the register port
`timescale 1ns/1ns
module rcc_host_model (
    input  wire logic mclk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_drv
);
    int nacks = 0;

    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_clk

    // Four cycles per clock phase, data moved mid low phase
    task automatic bit_io(input logic b, output logic r);
        wait_clk(2);
        sda_drv = b;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(2);
        r = sda_in;
        wait_clk(2);
        scl = 1'b0;
    endtask : bit_io

    // Also serves as repeated start
    task automatic start();
        wait_clk(2);
        sda_drv = 1'b1;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(4);
        sda_drv = 1'b0;
        wait_clk(4);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        wait_clk(2);
        sda_drv = 1'b0;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(4);
        sda_drv = 1'b1;
        wait_clk(4);
    endtask : stop

    task automatic wbyte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        if (r) nacks++;
    endtask : wbyte

    // Last byte of a read is refused by the host
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : rbyte
endmodule : rcc_host_model

// ### testbench/rcc_rtc_core_properties.sv
// Port-level properties of the calendar core
`timescale 1ns/1ns
module rcc_rtc_core_checker (
    input wire logic                  mclk,
    input wire logic                  reset,
    input wire logic                  tick_1hz,
    input wire rcc_pkg::rcc_i2c_in_t  i2c_in,
    input wire rcc_pkg::rcc_i2c_out_t i2c_out,
    input wire logic                  alarm_flag,
    input wire logic                  access_busy
);
    import rcc_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    AST_FLAG_RISE: assert property ($rose(alarm_flag) |->
        $past(tick_1hz, 2) || $past(tick_1hz, 3) || $past(access_busy, 2)
        || $past(access_busy, 3) || $past(access_busy, 4)
        || $past(access_busy, 5))
        else $error("alarm flag rose with no tick or access");
    AST_FLAG_FALL: assert property ($fell(alarm_flag) |->
        $past(access_busy) || $past(reset))
        else $error("alarm flag cleared outside a host write");
    AST_FLAG_HOLD: assert property ($rose(alarm_flag) |->
        alarm_flag [*8])
        else $error("alarm flag did not hold");
    AST_BUSY_RISE: assert property ($rose(access_busy) |->
        ##[0:1] i2c_out.sda_oe)
        else $error("freeze began without address acknowledge");
    AST_BUSY_FALL: assert property ($fell(access_busy) |->
        ($past(i2c_in.scl) && $past(i2c_in.sda)) || $past(reset))
        else $error("freeze ended without stop");
    AST_OE_AFTER_FALL: assert property ($rose(i2c_out.sda_oe) |->
        !$past(i2c_in.scl) && $past(i2c_in.scl, 2))
        else $error("data line pulled at wrong time");
    AST_OE_SCL_LOW: assert property ($changed(i2c_out.sda_oe) |->
        !i2c_in.scl)
        else $error("data line changed while bus clock high");
    AST_SDA_O_LOW: assert property (i2c_out.sda_o == 1'b0)
        else $error("open-drain data output not low");
endmodule : rcc_rtc_core_checker

bind rcc_rtc_core rcc_rtc_core_checker u_chk (
    .mclk        (mclk),
    .reset       (reset),
    .tick_1hz    (tick_1hz),
    .i2c_in      (i2c_in),
    .i2c_out     (i2c_out),
    .alarm_flag  (alarm_flag),
    .access_busy (access_busy)
);

// ### testbench/rcc_rtc_core_tb.sv
// Self-checking bench for the calendar core
`timescale 1ns/1ns
module rcc_rtc_core_tb;
    import rcc_pkg::*;

    typedef struct packed {
        rcc_time_t set;
        rcc_time_t exp;
    } rcc_row_t;

    logic         mclk;
    logic         reset;
    logic         tick_1hz;
    logic         supply_low;
    logic         scl;
    logic         sda_drv;
    logic         sda_w;
    rcc_i2c_in_t  i2c_in;
    rcc_i2c_out_t i2c_out;
    logic         alarm_flag;
    logic         access_busy;
    int           err_count = 0;
    int           tests_run = 0;
    logic [7:0]   q [9];
    logic [7:0]   d [9];
    logic [7:0]   rst_exp [9] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00,
                                  8'h01, 8'h00, 8'h80, 8'h80};
    // Time written, then expected after one tick
    rcc_row_t     rows [13] = '{
        {56'h59592331061299, 56'h00000001008100},
        {56'h59592328020204, 56'h00000029030204},
        {56'h59592329030204, 56'h00000001040304},
        {56'h59592328010203, 56'h00000001020303},
        {56'h59592328000200, 56'h00000029010200},
        {56'h59592330050421, 56'h00000001060521},
        {56'h59592331040121, 56'h00000001050221},
        {56'h59592330020921, 56'h00000001031021},
        {56'h59341215030721, 56'h00351215030721},
        {56'h59590915030721, 56'h00001015030721},
        {56'h59592330011121, 56'h00000001021221},
        {56'h59592330010321, 56'h00000031020321},
        {56'h59592331069299, 56'h00000001000100}
    };

    // Open-drain data line with pull-up
    assign sda_w  = sda_drv & ~i2c_out.sda_oe;
    assign i2c_in = {scl, sda_w};

    rcc_rtc_core u_dut (
        .mclk        (mclk),
        .reset       (reset),
        .tick_1hz    (tick_1hz),
        .supply_low  (supply_low),
        .i2c_in      (i2c_in),
        .i2c_out     (i2c_out),
        .alarm_flag  (alarm_flag),
        .access_busy (access_busy)
    );

    rcc_host_model u_host (
        .mclk    (mclk),
        .sda_in  (sda_w),
        .scl     (scl),
        .sda_drv (sda_drv)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] ptr, input int n);
        u_host.start();
        u_host.wbyte(8'ha2);
        u_host.wbyte({4'h0, ptr});
        for (int i = 0; i < n; i++) u_host.wbyte(d[i]);
        u_host.stop();
    endtask : wr

    task automatic rd(input logic [3:0] ptr, input int n);
        u_host.start();
        u_host.wbyte(8'ha2);
        u_host.wbyte({4'h0, ptr});
        u_host.start();
        u_host.wbyte(8'ha3);
        for (int i = 0; i < n; i++) u_host.rbyte(i == n - 1, q[i]);
        u_host.stop();
    endtask : rd

    task automatic tick();
        @(negedge mclk);
        tick_1hz = 1'b1;
        @(negedge mclk);
        tick_1hz = 1'b0;
        repeat (6) @(negedge mclk);
    endtask : tick

    task automatic set_time(input logic [7:0] hour);
        d = '{8'h59, 8'h00, hour, 8'h15, 8'h03, 8'h07, 8'h21, 8'h00, 8'h00};
        wr(4'h2, 7);
    endtask : set_time

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        repeat (90000) @(posedge mclk);
        err_count++;
        close_out();
    end

    initial begin
        reset      = 1'b1;
        tick_1hz   = 1'b0;
        supply_low = 1'b0;
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        check({7'h0, alarm_flag}, 8'h00);
        check({7'h0, access_busy}, 8'h00);
        rd(4'h2, 9);
        foreach (rst_exp[i]) check(q[i], rst_exp[i]);
        rd(4'hd, 1);
        check(q[0], 8'h00);
        $display("reset and map test done");

        foreach (rows[r]) begin
            for (int i = 0; i < 7; i++) d[i] = rows[r].set[55-8*i -: 8];
            wr(4'h2, 7);
            tick();
            rd(4'h2, 7);
            for (int i = 0; i < 7; i++) begin
                check(q[i], rows[r].exp[55-8*i -: 8]);
            end
        end
        $display("calendar table done");

        d = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
        wr(4'h2, 7);
        u_host.start();
        u_host.wbyte(8'ha2);
        u_host.wbyte(8'h02);
        u_host.start();
        u_host.wbyte(8'ha3);
        tick();
        tick();
        check({7'h0, access_busy}, 8'h01);
        u_host.rbyte(1'b1, q[0]);
        check(q[0], 8'h00);
        u_host.stop();
        rd(4'h2, 1);
        check(q[0], 8'h01);
        supply_low = 1'b1;
        repeat (2) @(negedge mclk);
        supply_low = 1'b0;
        rd(4'h2, 1);
        check(q[0], 8'h81);
        $display("freeze and supply test done");

        d[0] = 8'h01;
        d[1] = 8'h85;
        wr(4'h9, 2);
        set_time(8'h00);
        tick();
        check({7'h0, alarm_flag}, 8'h01);
        d[0] = 8'h08;
        wr(4'h1, 1);
        check({7'h0, alarm_flag}, 8'h01);
        d[0] = 8'h00;
        wr(4'h1, 1);
        check({7'h0, alarm_flag}, 8'h00);
        tick();
        check({7'h0, alarm_flag}, 8'h00);
        set_time(8'h00);
        d[0] = 8'h05;
        wr(4'ha, 1);
        tick();
        check({7'h0, alarm_flag}, 8'h00);
        set_time(8'h05);
        tick();
        check({7'h0, alarm_flag}, 8'h01);
        d = '{8'h81, 8'h85, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        wr(4'h9, 3);
        d[0] = 8'h00;
        wr(4'h1, 1);
        check({7'h0, alarm_flag}, 8'h00);
        d = '{8'h59, 8'h59, 8'h23, 8'h15, 8'h03, 8'h07, 8'h21, 8'h00, 8'h00};
        wr(4'h2, 7);
        tick();
        check({7'h0, alarm_flag}, 8'h01);
        check(u_host.nacks[7:0], 8'h00);
        $display("alarm test done");
        close_out();
    end
endmodule : rcc_rtc_core_tb
